// *** tb/rps_host.sv ***
// External reset source and boot strap model
`timescale 1ns/10ps
module rps_host
	import rps_pkg::*;
(
	input  wire logic                       clock_i,
	input  wire logic                       oe_i,
	input  wire logic [rps_pkg::BOOT_W-1:0] strap_i,
	output logic                            pin_o,
	output logic [rps_pkg::BOOT_W-1:0]      boot_o
);
	logic low_q = 1'b1;
	int   hi_q  = 0;
	// Open drain wire with pull-up; low from power-up until released
	assign pin_o = !(oe_i || low_q);
	// Straps held only 200 cycles past release, then scrambled
	assign boot_o = (hi_q < 200) ? strap_i : ~strap_i;
	always @(posedge clock_i) hi_q <= pin_o ? hi_q + 1 : 0;
	// Pin held low for n cycles, then let go
	task hold(input int n);
		@(posedge clock_i);
		low_q <= 1'b1;
		repeat (n) @(posedge clock_i);
		low_q <= 1'b0;
	endtask : hold
endmodule : rps_host

// *** tb/rps_seq_properties.sv ***
// Port checks for the reset and clock sequencer
`timescale 1ns/10ps
module rps_seq_properties
	import rps_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = 16
) (
	input wire logic                       clock_i,
	input wire logic                       arst_n_i,
	input wire logic                       device_reset_n_pin_i,
	input wire logic                       device_reset_n_pin_o,
	input wire logic                       device_reset_n_pin_oe_o,
	input wire logic                       watchdog_trigger_i,
	input wire logic [rps_pkg::BOOT_W-1:0] boot_mode_pin_i,
	input wire logic                       pll_multiplier_reg_wr_i,
	input wire logic [rps_pkg::MULT_W-1:0] pll_multiplier_reg_data_i,
	input wire logic                       core_reset_n_o,
	input wire logic                       bus_valid_o,
	input wire logic [rps_pkg::BOOT_W-1:0] boot_mode_o,
	input wire logic                       boot_mode_valid_o,
	input wire logic [rps_pkg::MULT_W-1:0] pll_multiplier_reg_o,
	input wire logic [rps_pkg::RATIO_W-1:0] pll_ratio_o,
	input wire logic                       pll_locking_o,
	input wire logic                       clk_sel_pll_o,
	input wire logic                       system_clock_out_o
);
	import rps_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	int unsigned wd_q, lk_q, low_q;
	// Cycle counts since watchdog start, last write, pin fall
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wd_q  <= 0;
			lk_q  <= 0;
			low_q <= 0;
		end else begin
			wd_q  <= (watchdog_trigger_i && !device_reset_n_pin_oe_o) ? 0 : wd_q + 1;
			lk_q  <= pll_multiplier_reg_wr_i ? 0 : lk_q + 1;
			low_q <= device_reset_n_pin_i ? 0 : low_q + 1;
		end
	end
	property p_od; !device_reset_n_pin_o; endproperty
	property p_wd_go; watchdog_trigger_i && !device_reset_n_pin_oe_o |=>
		device_reset_n_pin_oe_o; endproperty
	property p_wd_len; $fell(device_reset_n_pin_oe_o) |-> wd_q == 512; endproperty
	property p_filt; $fell(core_reset_n_o) |-> low_q >= 8 && low_q <= 12; endproperty
	property p_bus; $rose(core_reset_n_o) |-> ##33 $rose(bus_valid_o) && boot_mode_valid_o;
	endproperty
	property p_boot; $rose(boot_mode_valid_o) |-> boot_mode_o == $past(boot_mode_pin_i, 3);
	endproperty
	property p_wr; pll_multiplier_reg_wr_i |=> pll_locking_o && !clk_sel_pll_o &&
		pll_multiplier_reg_o == $past(pll_multiplier_reg_data_i); endproperty
	property p_lock; $fell(pll_locking_o) |-> lk_q == LOCK_CYCLES; endproperty
	property p_div; pll_locking_o && $past(pll_locking_o) |->
		system_clock_out_o != $past(system_clock_out_o); endproperty
	property p_ratio; $fell(pll_locking_o) |=> clk_sel_pll_o &&
		pll_ratio_o == pll_multiplier_reg_o[MULT_W-1:1]; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	a_wd_go: assert property (p_wd_go) else $error("pulse late");
	a_wd_len: assert property (p_wd_len) else $error("pulse length");
	a_filt: assert property (p_filt) else $error("short low taken");
	a_bus: assert property (p_bus) else $error("bus delay");
	a_boot: assert property (p_boot) else $error("strap capture");
	a_wr: assert property (p_wr) else $error("lock start");
	a_lock: assert property (p_lock) else $error("lock length");
	a_div: assert property (p_div) else $error("half clock");
	a_ratio: assert property (p_ratio) else $error("new ratio");
	c_wd: cover property ($fell(device_reset_n_pin_oe_o));
	c_bus: cover property ($rose(bus_valid_o));
	c_lock: cover property ($fell(pll_locking_o));
endmodule : rps_seq_properties
bind rps_seq rps_seq_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (.*);

// *** tb/rps_seq_tb.sv ***
// Testbench for the reset and clock sequencer
`timescale 1ns/10ps
module rps_seq_tb;
	import rps_pkg::*;
	localparam int unsigned LK = 16;
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic wd = 1'b0;
	logic wr = 1'b0;
	logic [MULT_W-1:0] dat = '0;
	logic [BOOT_W-1:0] strap = 4'hA;
	logic [BOOT_W-1:0] bpin, boot;
	logic pin, pin_o, oe, core, busv, bootv, lock, sel, sclk;
	logic [MULT_W-1:0] mreg;
	logic [RATIO_W-1:0] ratio;
	int errors = 0;
	int checks = 0;
	int n;
	always #25 clock_i = ~clock_i;
	rps_host u_host (.clock_i(clock_i), .oe_i(oe), .strap_i(strap), .pin_o(pin),
		.boot_o(bpin));
	rps_seq #(.LOCK_CYCLES(LK)) u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.device_reset_n_pin_i(pin), .device_reset_n_pin_o(pin_o),
		.device_reset_n_pin_oe_o(oe), .watchdog_trigger_i(wd), .boot_mode_pin_i(bpin),
		.pll_multiplier_reg_wr_i(wr), .pll_multiplier_reg_data_i(dat),
		.core_reset_n_o(core), .bus_valid_o(busv), .boot_mode_o(boot),
		.boot_mode_valid_o(bootv), .pll_multiplier_reg_o(mreg), .pll_ratio_o(ratio),
		.pll_locking_o(lock), .clk_sel_pll_o(sel), .system_clock_out_o(sclk));
	// Value compare
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task tick(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask : tick
	task final_report;
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// Release delay and strap capture
	task t_boot;
		for (n = 0; n < 100 && core !== 1'b1; n++) tick(1);
		for (n = 0; n < 100 && busv !== 1'b1; n++) tick(1);
		cmp(n, 33);
		cmp(bootv, 1'b1);
		cmp(boot, strap);
	endtask : t_boot
	// Glitch refused, warm reset taken
	task t_warm;
		u_host.hold(5);
		tick(20);
		cmp(core, 1'b1);
		u_host.hold(10);
		tick(2);
		cmp(core, 1'b0);
		cmp(busv, 1'b0);
		cmp(bootv, 1'b0);
		t_boot();
	endtask : t_warm
	// Watchdog pulse length and resulting reset
	task t_wdog;
		@(posedge clock_i) wd <= 1'b1;
		@(posedge clock_i) wd <= 1'b0;
		#1;
		for (n = 0; n < 600 && oe === 1'b1; n++) tick(1);
		cmp(n, 512);
		cmp(core, 1'b0);
		t_boot();
	endtask : t_wdog
	task wr_pll(input logic [MULT_W-1:0] d);
		@(posedge clock_i) begin
			wr  <= 1'b1;
			dat <= d;
		end
		@(posedge clock_i) wr <= 1'b0;
		#1;
	endtask : wr_pll
	// Lock phase, half clock, then new ratio
	task t_pll(input logic [MULT_W-1:0] d);
		logic s;
		wr_pll(d);
		cmp(mreg, d);
		cmp({lock, sel}, 2'b10);
		s = sclk;
		tick(1);
		cmp(sclk, !s);
		for (n = 1; n < 100 && lock === 1'b1; n++) tick(1);
		cmp(n, LK);
		tick(1);
		cmp(sel, 1'b1);
		cmp(ratio, d >> 1);
	endtask : t_pll
	initial begin
		#(6000 * 50);
		errors++;
		final_report();
	end
	initial begin
		tick(20);
		cmp(mreg, PLL_MULT_RST);
		cmp(ratio, 15'h0002);
		cmp(sel, 1'b1);
		cmp(core, 1'b0);
		cmp({oe, pin_o}, 2'b00);
		cmp({busv, bootv}, 2'b00);
		cmp({lock, sclk}, 2'b00);
		@(posedge clock_i) arst_n_i <= 1'b1;
		u_host.hold(8);
		t_boot();
		t_warm();
		t_wdog();
		t_pll(16'h0008);
		wr_pll(16'h0004);
		tick(5);
		t_pll(16'h0008);
		t_pll(16'h0004);
		final_report();
	end
endmodule : rps_seq_tb

// *** verilog/rps_pkg.sv ***
// Constants and types shared by the reset and clock sequencing block
package rps_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int unsigned BOOT_W     = 4;
	localparam int unsigned MULT_W     = 16;
	localparam int unsigned RATIO_W    = 15;
	localparam int unsigned FILT_W     = 4;

	// ---------------------------------------------------------------
	// Timing counts, in oscillator clock cycles
	// ---------------------------------------------------------------
	localparam int unsigned RST_LOW_MIN_CYC = 8;       // Warm reset recognition
	localparam int unsigned WD_PULSE_CYC    = 512;     // Watchdog reset pulse
	localparam int unsigned BUS_DELAY_CYC   = 32;      // Release timer load; bus valid one cycle later
	localparam int unsigned BOOT_HOLD_CYC   = 200;     // Strap hold after release
	localparam int unsigned LOCK_CYC        = 131072;  // PLL lock phase
	localparam int unsigned LOCK_DIV        = 2;       // Clock divide while locking

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [MULT_W-1:0]  PLL_MULT_RST = 16'h0004;
	localparam logic [BOOT_W-1:0]  BOOT_RST     = 4'h0;

	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HELD,
		ST_WAIT,
		ST_RUN
	} rps_state_t;

endpackage : rps_pkg

// *** verilog/rps_seq.sv ***
// Reset pin sequencing, boot strap capture and PLL relock sequencing
//
// Overview of operation
// - Watchdog drives reset low 512 cycles
// - Bus valid 33 cycles after reset rises
// - Sample boot straps when bus goes valid, 33 cycles after reset rises
// - Multiplier write starts lock phase at once
// - Lock phase gives oscillator clock halved
// - Lock lasts 131072 cycles, then new ratio
// - Multiplier value gives clock times half value
`timescale 1ns/10ps
module rps_seq
	import rps_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = rps_pkg::LOCK_CYC
) (
	input  wire logic                        clock_i,
	input  wire logic                        arst_n_i,
	input  wire logic                        device_reset_n_pin_i,
	output logic                             device_reset_n_pin_o,
	output logic                             device_reset_n_pin_oe_o,
	input  wire logic                        watchdog_trigger_i,
	input  wire logic [rps_pkg::BOOT_W-1:0]  boot_mode_pin_i,
	input  wire logic                        pll_multiplier_reg_wr_i,
	input  wire logic [rps_pkg::MULT_W-1:0]  pll_multiplier_reg_data_i,
	output logic                             core_reset_n_o,
	output logic                             bus_valid_o,
	output logic [rps_pkg::BOOT_W-1:0]       boot_mode_o,
	output logic                             boot_mode_valid_o,
	output logic [rps_pkg::MULT_W-1:0]       pll_multiplier_reg_o,
	output logic [rps_pkg::RATIO_W-1:0]      pll_ratio_o,
	output logic                             pll_locking_o,
	output logic                             clk_sel_pll_o,
	output logic                             system_clock_out_o
);

	import rps_pkg::*;

	localparam int unsigned LOCK_W = $clog2(LOCK_CYCLES + 1);
	localparam int unsigned WD_W   = $clog2(WD_PULSE_CYC + 1);
	localparam int unsigned REL_W  = $clog2(BUS_DELAY_CYC + 1);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic              pin_s1_q;
	logic              pin_s2_q;
	logic [BOOT_W-1:0] boot_s1_q;
	logic [BOOT_W-1:0] boot_s2_q;

	// Reset pin is asynchronous to the oscillator clock
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= device_reset_n_pin_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Straps are static, but still pass two flops before use
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_s1_q <= BOOT_RST;
			boot_s2_q <= BOOT_RST;
		end else begin
			boot_s1_q <= boot_mode_pin_i;
			boot_s2_q <= boot_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Low-pulse filter
	// ---------------------------------------------------------------
	logic [FILT_W-1:0] low_cnt_q;
	logic              rst_seen;

	// Shorter glitches on the pin never reach the core
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			low_cnt_q <= '0;
		end else if (pin_s2_q) begin
			low_cnt_q <= '0;
		end else if (low_cnt_q != FILT_W'(RST_LOW_MIN_CYC)) begin
			low_cnt_q <= low_cnt_q + FILT_W'(1);
		end
	end

	assign rst_seen = !pin_s2_q && (low_cnt_q == FILT_W'(RST_LOW_MIN_CYC - 1));

	// ---------------------------------------------------------------
	// Watchdog pulse onto the open-drain reset pin
	// ---------------------------------------------------------------
	logic wd_busy;
	logic wd_start;
	logic pin_drive_q;

	// A trigger during a pulse is ignored rather than stretching it
	assign wd_start = watchdog_trigger_i && !wd_busy;

	rps_timer #(
		.WIDTH (WD_W)
	) u_wd_timer (
		.clock_i  (clock_i),
		.arst_n_i (arst_n_i),
		.start_i  (wd_start),
		.load_i   (WD_W'(WD_PULSE_CYC)),
		.busy_o   (wd_busy),
		.done_o   ()
	);

	// Open drain: only ever pulls low
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_drive_q <= 1'b0;
		end else begin
			pin_drive_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Reset sequencer
	// ---------------------------------------------------------------
	rps_state_t        state_q;
	logic              rel_start;
	logic              rel_done;
	logic              core_rst_n_q;
	logic              bus_valid_q;
	logic [BOOT_W-1:0] boot_q;
	logic              boot_valid_q;

	// Power-up begins held; the host keeps the pin low meanwhile
	assign rel_start = (state_q == ST_HELD) && pin_s2_q;

	rps_timer #(
		.WIDTH (REL_W)
	) u_rel_timer (
		.clock_i  (clock_i),
		.arst_n_i (arst_n_i),
		.start_i  (rel_start),
		.load_i   (REL_W'(BUS_DELAY_CYC)),
		.busy_o   (),
		.done_o   (rel_done)
	);

	// State register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= ST_HELD;
		end else begin
			case (state_q)
				ST_HELD: begin
					if (pin_s2_q) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (rst_seen) begin
						state_q <= ST_HELD;
					end else if (rel_done) begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (rst_seen) begin
						state_q <= ST_HELD;
					end
				end
				default: begin
					state_q <= ST_HELD;
				end
			endcase
		end
	end

	// Core reset follows the qualified pin level
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			core_rst_n_q <= 1'b0;
		end else if (rst_seen) begin
			core_rst_n_q <= 1'b0;
		end else if (rel_start) begin
			core_rst_n_q <= 1'b1;
		end
	end

	// Address and data only go valid once the release delay has run
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_valid_q <= 1'b0;
		end else if (rst_seen) begin
			bus_valid_q <= 1'b0;
		end else if (state_q == ST_WAIT && rel_done) begin
			bus_valid_q <= 1'b1;
		end
	end

	// Captured well inside the host's strap hold window
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			boot_q       <= BOOT_RST;
			boot_valid_q <= 1'b0;
		end else if (rst_seen) begin
			boot_valid_q <= 1'b0;
		end else if (state_q == ST_WAIT && rel_done) begin
			boot_q       <= boot_s2_q;
			boot_valid_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// PLL relock sequencing
	// ---------------------------------------------------------------
	logic                lock_busy;
	logic                lock_done;
	logic [MULT_W-1:0]   mult_q;
	logic [RATIO_W-1:0]  ratio_q;
	logic                sel_pll_q;
	logic                half_clk_q;

	rps_timer #(
		.WIDTH (LOCK_W)
	) u_lock_timer (
		.clock_i  (clock_i),
		.arst_n_i (arst_n_i),
		.start_i  (pll_multiplier_reg_wr_i),
		.load_i   (LOCK_W'(LOCK_CYCLES)),
		.busy_o   (lock_busy),
		.done_o   (lock_done)
	);

	// The register takes the new value at once
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mult_q <= PLL_MULT_RST;
		end else if (pll_multiplier_reg_wr_i) begin
			mult_q <= pll_multiplier_reg_data_i;
		end
	end

	// Ratio applies only after lock so the core never sees a wild clock
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ratio_q <= PLL_MULT_RST[MULT_W-1:1];
		end else if (lock_done) begin
			ratio_q <= mult_q[MULT_W-1:1];
		end
	end

	// Mux select: half clock while locking, PLL output afterwards
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_pll_q <= 1'b1;
		end else if (pll_multiplier_reg_wr_i) begin
			sel_pll_q <= 1'b0;
		end else if (lock_done) begin
			sel_pll_q <= 1'b1;
		end
	end

	// Divide by two is a plain toggle; parked low outside the lock phase
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			half_clk_q <= 1'b0;
		end else if (!lock_busy) begin
			half_clk_q <= 1'b0;
		end else begin
			half_clk_q <= ~half_clk_q;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign device_reset_n_pin_o    = pin_drive_q;
	assign device_reset_n_pin_oe_o = wd_busy;
	assign core_reset_n_o          = core_rst_n_q;
	assign bus_valid_o             = bus_valid_q;
	assign boot_mode_o             = boot_q;
	assign boot_mode_valid_o       = boot_valid_q;
	assign pll_multiplier_reg_o    = mult_q;
	assign pll_ratio_o             = ratio_q;
	assign pll_locking_o           = lock_busy;
	assign clk_sel_pll_o           = sel_pll_q;
	assign system_clock_out_o      = half_clk_q;

endmodule : rps_seq

// *** verilog/rps_timer.sv ***
// One-shot down-counter giving a busy window and an end pulse
`timescale 1ns/10ps
module rps_timer #(
	parameter int unsigned WIDTH = 10
) (
	input  wire logic             clock_i,
	input  wire logic             arst_n_i,
	input  wire logic             start_i,
	input  wire logic [WIDTH-1:0] load_i,
	output logic                  busy_o,
	output logic                  done_o
);

	logic [WIDTH-1:0] count_q;
	logic             busy_q;
	logic             done_q;

	// ---------------------------------------------------------------
	// Counter; a start while running reloads the full length
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_q <= '0;
		end else if (start_i) begin
			count_q <= load_i;
		end else if (count_q != '0) begin
			count_q <= count_q - WIDTH'(1);
		end
	end

	// Busy covers exactly load_i cycles from the start edge
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= start_i | (count_q > WIDTH'(1));
		end
	end

	// One-cycle pulse when the count runs out
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= !start_i && (count_q == WIDTH'(1));
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;

endmodule : rps_timer
